// File: hdl/slot_event_pkg.sv
// Constants and types for the slot event enable block.
// Assumes a 32-bit classic Wishbone bus and one 100 MHz clock.
package slot_event_pkg;
	// ==========================================
	// Register map
	localparam logic [4:0] ADDR_SLOT_CTL = 5'h00;
	localparam logic [4:0] ADDR_SLOT_STAT = 5'h04;
	localparam logic [4:0] ADDR_PORT_CFG = 5'h08;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
	// ==========================================
	// Slot control fields
	localparam int LAMP_LSB = 6;
	localparam int HP_EN_BIT = 5;
	localparam int CMD_EN_BIT = 4;
	localparam int PRES_EN_BIT = 3;
	localparam int LATCH_EN_BIT = 2;
	// Slot status and interrupt status fields
	localparam int CMD_BIT = 0;
	localparam int PRES_BIT = 1;
	localparam int LATCH_BIT = 2;
	localparam int HPI_BIT = 0;
	localparam int PME_BIT = 1;
	// Port configuration fields
	localparam int MESSAGE_IRQ_ENABLE_BIT = 0;
	localparam int WAKE_EN_BIT = 1;
	localparam int PSTATE_LSB = 2;
	// ==========================================
	// Lamp codes and power states
	localparam logic [1:0] LAMP_RSVD = 2'h0;
	localparam logic [1:0] LAMP_ON = 2'h1;
	localparam logic [1:0] LAMP_BLINK = 2'h2;
	localparam logic [1:0] LAMP_OFF = 2'h3;
	typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3HOT} power_state_e;
	// ==========================================
	// Reset values and timing
	localparam logic [1:0] LAMP_RESET = LAMP_OFF;
	localparam int CLK_MHZ = 100;
	localparam int CMD_TIME_NS = 1000;
	localparam int CMD_CYCLES = CMD_TIME_NS * CLK_MHZ / 1000;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;
	// ==========================================
	// Slot control register image
	typedef struct packed {
		logic [1:0] attention_lamp_control;
		logic hotplug_irq_enable;
		logic cmd_done_irq_enable;
		logic presence_change_enable;
		logic latch_change_enable;
	} slot_ctl_s;
	localparam slot_ctl_s SLOT_CTL_RESET = '{LAMP_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
	// Event flags of the slot status register
	typedef struct packed {
		logic latch_changed_flag;
		logic presence_changed_flag;
		logic cmd_done_flag;
	} slot_flags_s;
endpackage : slot_event_pkg

// File: hdl/hotplug_slot_event_enables.sv
// Slot control enables of a downstream port hot-plug controller.
// Assumes a classic Wishbone master on ref_clk and asynchronous slot pins.
//
// Overview of operation
// (RQ1) Lamp field bits 7:6: 00 reserved, 01 on, 10 blinking, 11 off; drives lamp pin.
// (RQ2) Bit 5 enables hot-plug interrupts for enabled events; 0 suppresses all.
// (RQ3) Bit 4 enables the interrupt raised when a slot command completes.
// (RQ4) A write changing a slot-control output field starts a command.
// (RQ5) Interrupt only when event enable, global enable and message enable are set.
// (RQ6) Bit 3 allows interrupt or PME on presence-changed flag; 0 suppresses both.
// (RQ7) In D1, D2 or D3hot a PME needs the wake enable as well.
// (RQ8) Bit 2 allows interrupt or PME on latch-changed flag; 0 suppresses both.
// (RQ9) One interrupt per rising assertion of an enabled event, not repeated.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module hotplug_slot_event_enables #(
	parameter int BLINK_HALF = slot_event_pkg::BLINK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Slot sensor pins
	input wire logic presence_pin,
	input wire logic latch_pin,
	// Upstream signalling
	output logic hotplug_irq_pulse,
	output logic wake_event_pulse,
	output logic irq,
	// Indicator
	output logic attention_lamp_pin
);
	import slot_event_pkg::*;

	localparam int CMD_W = $clog2(CMD_CYCLES + 1);
	localparam int BLINK_W = $clog2(BLINK_HALF + 1);

	slot_ctl_s ctl;
	slot_flags_s flags;
	logic message_irq_enable;
	logic wake_event_enable;
	power_state_e pstate;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [1:0] pres_sync;
	logic [1:0] latch_sync;
	logic pres_q;
	logic latch_q;
	logic [CMD_W-1:0] cmd_count;
	logic cmd_busy;
	logic [BLINK_W-1:0] blink_count;
	logic blink_phase;
	logic [2:0] cond_q;

	// ==========================================
	// Bus decode
	logic req;
	logic wr_take;
	logic [31:0] next_rdata;
	logic [31:0] wmask;
	slot_ctl_s next_ctl;
	logic cmd_start;
	logic pres_edge;
	logic latch_edge;
	logic cmd_finish;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	function automatic logic hit(input logic [4:0] adr, input logic [4:0] reg_adr);
		hit = (adr == reg_adr);
	endfunction : hit

	assign req = wb_cyc_i & wb_stb_i;
	// A write lands on the edge at which the master samples ack
	assign wr_take = req & wb_ack_o & wb_we_i;
	assign wmask = lane_mask(wb_sel_i) & wb_dat_i;

	always_comb begin
		next_ctl = ctl;
		if (wr_take && hit(wb_adr_i, ADDR_SLOT_CTL) && wb_sel_i[0]) begin
			next_ctl = slot_ctl_s'(wb_dat_i[LAMP_LSB+1:LATCH_EN_BIT]);
		end
	end

	// Only the lamp field drives an output, so only it forms a command
	assign cmd_start = (next_ctl.attention_lamp_control != ctl.attention_lamp_control); // RQ4

	always_comb begin
		next_rdata = 32'h0;
		unique case (wb_adr_i)
			ADDR_SLOT_CTL: next_rdata[LAMP_LSB+1:LATCH_EN_BIT] = ctl;
			ADDR_SLOT_STAT: next_rdata[LATCH_BIT:CMD_BIT] = flags;
			ADDR_PORT_CFG: begin
				next_rdata[MESSAGE_IRQ_ENABLE_BIT] = message_irq_enable;
				next_rdata[WAKE_EN_BIT] = wake_event_enable;
				next_rdata[PSTATE_LSB+1:PSTATE_LSB] = pstate;
			end
			ADDR_IRQ_STAT: next_rdata[PME_BIT:HPI_BIT] = irq_stat;
			ADDR_IRQ_MASK: next_rdata[PME_BIT:HPI_BIT] = irq_mask;
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req && !wb_ack_o) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= SLOT_CTL_RESET;
		end else begin
			ctl <= next_ctl;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			message_irq_enable <= 1'b0;
			wake_event_enable <= 1'b0;
			pstate <= PS_D0;
			irq_mask <= 2'h0;
		end else if (wr_take && wb_sel_i[0]) begin
			if (hit(wb_adr_i, ADDR_PORT_CFG)) begin
				message_irq_enable <= wb_dat_i[MESSAGE_IRQ_ENABLE_BIT];
				wake_event_enable <= wb_dat_i[WAKE_EN_BIT];
				pstate <= power_state_e'(wb_dat_i[PSTATE_LSB+1:PSTATE_LSB]);
			end
			if (hit(wb_adr_i, ADDR_IRQ_MASK)) begin
				irq_mask <= wb_dat_i[PME_BIT:HPI_BIT];
			end
		end
	end

	// ==========================================
	// Sensor synchronisers and change detect
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pres_sync <= 2'h0;
			latch_sync <= 2'h0;
			pres_q <= 1'b0;
			latch_q <= 1'b0;
		end else begin
			pres_sync <= {pres_sync[0], presence_pin};
			latch_sync <= {latch_sync[0], latch_pin};
			pres_q <= pres_sync[1];
			latch_q <= latch_sync[1];
		end
	end

	// Both edges count; the first compare after reset may see a change
	assign pres_edge = pres_sync[1] ^ pres_q;
	assign latch_edge = latch_sync[1] ^ latch_q;

	// ==========================================
	// Command timer
	assign cmd_finish = cmd_busy && (cmd_count == CMD_W'(1));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_busy <= 1'b0;
			cmd_count <= '0;
		end else if (cmd_start) begin
			// A new command while one runs restarts the timer
			cmd_busy <= 1'b1;
			cmd_count <= CMD_W'(CMD_CYCLES);
		end else if (cmd_busy) begin
			cmd_count <= cmd_count - CMD_W'(1);
			cmd_busy <= ~cmd_finish;
		end
	end

	// ==========================================
	// Slot status flags, write one to clear; a set in the same cycle wins
	logic [2:0] stat_clr;
	logic [2:0] stat_set;
	assign stat_clr = (wr_take && hit(wb_adr_i, ADDR_SLOT_STAT)) ? wmask[LATCH_BIT:CMD_BIT] : 3'h0;
	assign stat_set = {latch_edge, pres_edge, cmd_finish};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
		end else begin
			flags <= slot_flags_s'((flags & ~stat_clr) | stat_set);
		end
	end

	// ==========================================
	// Event gating
	logic [2:0] cond;
	logic [2:0] rise;
	logic low_power;
	logic irq_allowed;
	logic fire_irq;
	logic fire_pme;

	assign cond[CMD_BIT] = flags.cmd_done_flag & ctl.cmd_done_irq_enable; // RQ3
	assign cond[PRES_BIT] = flags.presence_changed_flag & ctl.presence_change_enable; // RQ6
	assign cond[LATCH_BIT] = flags.latch_changed_flag & ctl.latch_change_enable; // RQ8
	assign rise = cond & ~cond_q; // RQ9
	assign low_power = (pstate != PS_D0);
	assign irq_allowed = ctl.hotplug_irq_enable & message_irq_enable; // RQ2 RQ5
	// Interrupts in D0; in lower states presence and latch wake the host instead
	assign fire_irq = irq_allowed && !low_power && (rise != 3'h0); // RQ5
	assign fire_pme = low_power && wake_event_enable && (rise[LATCH_BIT:PRES_BIT] != 2'h0); // RQ7

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_q <= 3'h0;
			hotplug_irq_pulse <= 1'b0;
			wake_event_pulse <= 1'b0;
		end else begin
			cond_q <= cond;
			hotplug_irq_pulse <= fire_irq; // RQ2
			wake_event_pulse <= fire_pme; // RQ7
		end
	end

	// ==========================================
	// Local interrupt status and level output
	logic [1:0] irq_clr;
	logic [1:0] irq_set;
	assign irq_clr = (wr_take && hit(wb_adr_i, ADDR_IRQ_STAT)) ? wmask[PME_BIT:HPI_BIT] : 2'h0;
	assign irq_set = {fire_pme, fire_irq};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	// ==========================================
	// Attention lamp
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_count <= '0;
			blink_phase <= 1'b0;
		end else if (blink_count == BLINK_W'(BLINK_HALF - 1)) begin
			blink_count <= '0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_count <= blink_count + BLINK_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			attention_lamp_pin <= 1'b0;
		end else begin
			unique case (ctl.attention_lamp_control)
				LAMP_ON: attention_lamp_pin <= 1'b1; // RQ1
				LAMP_BLINK: attention_lamp_pin <= blink_phase; // RQ1
				LAMP_OFF: attention_lamp_pin <= 1'b0; // RQ1
				// Reserved code keeps the lamp as it was
				LAMP_RSVD: attention_lamp_pin <= attention_lamp_pin; // RQ1
			endcase
		end
	end
endmodule : hotplug_slot_event_enables

// File: test/hotplug_slot_event_checker.sv
// Port-level assertions for the slot event enables block.
// Assumes it is bound onto the block; control and config are shadowed from bus writes.
`timescale 1ns/100ps
module hotplug_slot_event_checker
	import slot_event_pkg::*;
#(parameter int BLINK_HALF = 4) (
	// Watched ports
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic hotplug_irq_pulse,
	input wire logic wake_event_pulse,
	input wire logic attention_lamp_pin
);
	// ==========================================
	// Shadow registers
	logic [7:0] ctl;
	logic [3:0] cfg;
	wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= 8'hc0;
			cfg <= 4'h0;
		end else if (wr && wb_adr_i == ADDR_SLOT_CTL) begin
			ctl <= wb_dat_i[7:0];
		end else if (wr && wb_adr_i == ADDR_PORT_CFG) begin
			cfg <= wb_dat_i[3:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	hp_once_a: assert property (hotplug_irq_pulse |=> !hotplug_irq_pulse)
		else $error("hotplug pulse too long");
	wake_once_a: assert property (wake_event_pulse |=> !wake_event_pulse)
		else $error("wake pulse too long");
	hp_global_a: assert property (hotplug_irq_pulse |-> $past(ctl[5]))
		else $error("hotplug pulse without global enable");
	hp_msg_a: assert property (hotplug_irq_pulse |-> $past(cfg[0]) && $past(cfg[3:2]) == 2'h0)
		else $error("hotplug pulse without message enable");
	hp_src_a: assert property (hotplug_irq_pulse |-> $past(ctl[4:2]) != 3'h0)
		else $error("hotplug pulse without event enable");
	wake_gate_a: assert property (wake_event_pulse |-> $past(cfg[1]) && $past(cfg[3:2]) != 2'h0)
		else $error("wake pulse not gated");
	wake_src_a: assert property (wake_event_pulse |-> $past(ctl[3:2]) != 2'h0)
		else $error("wake pulse without event enable");
	lamp_on_a: assert property (ctl[7:6] == LAMP_ON && $past(ctl[7:6]) == LAMP_ON |-> attention_lamp_pin)
		else $error("lamp not lit");
	lamp_off_a: assert property (ctl[7:6] == LAMP_OFF && $past(ctl[7:6]) == LAMP_OFF |-> !attention_lamp_pin)
		else $error("lamp not dark");
	cover property (hotplug_irq_pulse);
	cover property (wake_event_pulse);
	cover property (ctl[7:6] == LAMP_BLINK ##1 attention_lamp_pin);
endmodule : hotplug_slot_event_checker

bind hotplug_slot_event_enables hotplug_slot_event_checker #(.BLINK_HALF(BLINK_HALF)) chk_i (.ref_clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
	.hotplug_irq_pulse, .wake_event_pulse, .attention_lamp_pin);

// File: test/upstream_host_model.sv
// Upstream host that receives interrupt and wake requests.
// Assumes one-cycle request pulses on ref_clk.
`timescale 1ns/100ps
module upstream_host_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Requests
	input wire logic hotplug_irq_pulse,
	input wire logic wake_event_pulse,
	// Tallies
	output int hp_n,
	output int pme_n
);
	// ==========================================
	// A host takes every message at once, so no back-pressure
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hp_n <= 0;
			pme_n <= 0;
		end else begin
			hp_n <= hp_n + int'(hotplug_irq_pulse);
			pme_n <= pme_n + int'(wake_event_pulse);
		end
	end
endmodule : upstream_host_model

// File: test/hotplug_slot_event_enables_tb_top.sv
// Self-checking bench for the slot event enables block.
// Assumes the package constants and a Wishbone slave acking one cycle after the request.
`timescale 1ns/100ps
module hotplug_slot_event_enables_tb_top;
	import slot_event_pkg::*;
	logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic presence_pin = 0, latch_pin = 0, lp = 0;
	logic [4:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o;
	logic wb_ack_o, hotplug_irq_pulse, wake_event_pulse, irq, attention_lamp_pin;
	int err_total = 0, comparisons = 0, cyc = 0, pushed = 0, tg = 0, hp_n, pme_n;
	logic [31:0] q[$], rq[$];
	hotplug_slot_event_enables #(.BLINK_HALF(4)) uut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .presence_pin, .latch_pin,
		.hotplug_irq_pulse, .wake_event_pulse, .irq, .attention_lamp_pin);
	upstream_host_model host (.ref_clk, .rst_n, .hotplug_irq_pulse, .wake_event_pulse, .hp_n, .pme_n);
	initial forever #5 ref_clk = ~ref_clk;
	// ==========================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task report_and_stop;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task bus(input logic [4:0] a, input logic [31:0] d, input logic w);
		@(posedge ref_clk);
		// Random filler in the unused upper bytes must never reach a field
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d | ($urandom() << 8), 4'hf};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : bus
	task rd(input logic [4:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(a, 32'h0, 1'b0);
	endtask : rd
	task note(input logic [31:0] e);
		q.push_back(e);
		pushed++;
	endtask : note
	task lamp(input logic [1:0] c, input logic e);
		bus(ADDR_SLOT_CTL, {24'h0, c, 6'h0}, 1'b1);
		repeat (3) @(posedge ref_clk);
		chk("lamp", 32'(e), 32'(attention_lamp_pin));
	endtask : lamp
	// Sensor edge after clearing status; expected pulse code is {hotplug, wake}
	task ev(input bit lat, input logic [31:0] clr, input logic [31:0] e);
		bus(ADDR_SLOT_STAT, clr, 1'b1);
		if (e != 0) note(e);
		@(posedge ref_clk);
		if (lat) latch_pin <= ~latch_pin;
		else presence_pin <= ~presence_pin;
		repeat ($urandom_range(30, 12)) @(posedge ref_clk);
	endtask : ev
	always @(posedge ref_clk) if (rst_n) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk("read", rq.pop_front(), wb_dat_o);
		if (hotplug_irq_pulse || wake_event_pulse) chk("pulse", q.size() ? q.pop_front() : 0,
			{hotplug_irq_pulse, wake_event_pulse});
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop;
		end
	end
	initial begin
		void'($urandom(32'h9ad5));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_SLOT_CTL, 32'hc0);
		rd(5'h14, 32'h0);
		lamp(LAMP_ON, 1'b1);
		lamp(LAMP_RSVD, 1'b1);
		lamp(LAMP_OFF, 1'b0);
		lamp(LAMP_RSVD, 1'b0);
		bus(ADDR_SLOT_CTL, 32'h80, 1'b1);
		repeat (24) begin
			@(posedge ref_clk);
			tg += int'(attention_lamp_pin !== lp);
			lp = attention_lamp_pin;
		end
		chk("blink", 32'h1, 32'(tg > 2));
		repeat (110) @(posedge ref_clk);
		bus(ADDR_PORT_CFG, 32'h1, 1'b1);
		bus(ADDR_IRQ_MASK, 32'h1, 1'b1);
		bus(ADDR_SLOT_STAT, 32'h7, 1'b1);
		note(32'h2);
		bus(ADDR_SLOT_CTL, 32'h70, 1'b1);
		repeat (130) @(posedge ref_clk);
		chk("irq", 32'h1, 32'(irq));
		bus(ADDR_SLOT_STAT, 32'h1, 1'b1);
		bus(ADDR_SLOT_CTL, 32'h70, 1'b1);
		repeat (130) @(posedge ref_clk);
		bus(ADDR_IRQ_MASK, 32'h0, 1'b1);
		repeat (2) @(posedge ref_clk);
		chk("irq", 32'h0, 32'(irq));
		bus(ADDR_IRQ_STAT, 32'h3, 1'b1);
		rd(ADDR_IRQ_STAT, 32'h0);
		bus(ADDR_SLOT_CTL, 32'h48, 1'b1);
		ev(1'b0, 32'h7, 32'h0);
		bus(ADDR_SLOT_CTL, 32'h60, 1'b1);
		note(32'h2);
		bus(ADDR_SLOT_CTL, 32'h68, 1'b1);
		ev(1'b0, 32'h0, 32'h0);
		ev(1'b0, 32'h2, 32'h2);
		bus(ADDR_PORT_CFG, 32'h0, 1'b1);
		ev(1'b0, 32'h2, 32'h0);
		for (int i = 1; i < 4; i++) begin
			bus(ADDR_SLOT_STAT, 32'h7, 1'b1);
			bus(ADDR_PORT_CFG, 32'(i * 4 + 2), 1'b1);
			ev(1'b0, 32'h2, 32'h1);
		end
		bus(ADDR_SLOT_CTL, 32'h44, 1'b1);
		ev(1'b1, 32'h6, 32'h1);
		bus(ADDR_PORT_CFG, 32'hc, 1'b1);
		ev(1'b1, 32'h4, 32'h0);
		bus(ADDR_SLOT_CTL, 32'h40, 1'b1);
		bus(ADDR_PORT_CFG, 32'he, 1'b1);
		ev(1'b1, 32'h4, 32'h0);
		repeat (20) @(posedge ref_clk);
		chk("pending", 32'h0, q.size());
		chk("host", pushed, hp_n + pme_n);
		report_and_stop;
	end
endmodule : hotplug_slot_event_enables_tb_top
